// >>> design/mlc_pkg.sv
// Package: register map, field positions, reset values and codes for the line config block
package mlc_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address divided by four)
    // ------------------------------------------------------------
    localparam logic [3:0]  IDX_OUT_PROTO   = 4'h0;
    localparam logic [3:0]  IDX_IN_PROTO    = 4'h1;
    localparam logic [3:0]  IDX_IF_CFG      = 4'h2;
    localparam logic [3:0]  IDX_RX_STATUS   = 4'h3;
    localparam logic [3:0]  IDX_CAUSE_MASK  = 4'h4;
    localparam logic [3:0]  IDX_LINE_SRC    = 4'h5;
    localparam logic [3:0]  IDX_DTR_CTRL    = 4'h6;
    localparam logic [3:0]  IDX_RTS_CTRL    = 4'h7;
    localparam logic [3:0]  IDX_RL_CTRL     = 4'h8;
    localparam logic [3:0]  IDX_LL_CTRL     = 4'h9;
    localparam logic [3:0]  IDX_ADAPT_CTRL  = 4'ha;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OUT_CONT_BIT   = 7;
    localparam int CFG_LOCAL_BIT  = 0;
    localparam int CFG_REMOTE_BIT = 1;
    localparam int CFG_TXC_OUT    = 2;
    localparam int CFG_OUT_EN     = 3;
    localparam int SRC_DTR_BIT    = 0;
    localparam int SRC_RTS_BIT    = 1;
    localparam int SRC_RL_BIT     = 2;
    localparam int SRC_LL_BIT     = 3;
    localparam int ADC_ST_PIN_BIT = 0;
    localparam int ADC_INTERR_BIT = 3;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  PROTO_OFF       = 4'h0;
    localparam logic [15:0] PROTO_VALID     = 16'h737f; // unused codes 7, 10, 11, 15 clear
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam logic [3:0]  UNDEF_HIGH_BITS = 4'h0;     // Readback of undefined bits
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;
    localparam logic [2:0]  HSIZE_WORD      = 3'b010;

endpackage : mlc_pkg

// >>> design/mlc_line_config.sv
// Module: register bank and line routing of a multi-protocol serial transceiver
//
// Contract
// - Output protocol code selects driver standard; 0000 off.
// - Drivers off until output protocol written once.
// - Input protocol code configures receivers; 0000 disables.
// - Input protocol readable; low nibble is code.
// - Both loopback bits clear gives normal pass-through.
// - Local loopback feeds transmit into receive side.
// - Remote loopback returns line inputs to drivers.
// - Both loopbacks apply independently on each side.
// - Config bit 2 sets transmit clock direction.
// - Adapter bit 0 picks terminal or send timing.
// - Reset clears configuration; drivers disabled.
// - Interrogation enable clears output enable bit.
// - Loopback pairs TxD-RxD, clocks, RTS-CTS, DTR-DSR, LL-RI, RL-DCD.
// - Status register shows RI DCD DSR CTS, low true.
// - Cause register top nibble equals present status.
// - Cause bit sets when line differs from holder.
// - Interrupt asserted while any cause bit set.
// - Cause bits stay set until cause read.
// - Cause read clears, reloads holder with present; the code keeps a bit set for a step seen at the read edge.
// - Mask write stores four enables gating causes.
// - Source bit 0 picks DTR pin or register.
// - Source bit 1 picks RTS pin or register.
// - Continuous mode always enables; multidrop uses DTR.
// - Internal DTR register drives DTR level.
`timescale 1ns/1ps
`default_nettype none

module mlc_line_config
    import mlc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Logic-side pins
    input  wire logic        txd_in,
    input  wire logic        txc_in,
    input  wire logic        rts_in,
    input  wire logic        dtr_in,
    input  wire logic        rl_in,
    input  wire logic        ll_in,
    output logic             rxd_out,
    output logic             rxc_out,
    output logic             cts_out,
    output logic             dsr_out,
    output logic             ri_out,
    output logic             dcd_out,
    output logic             txc_out,
    output logic             irq,
    // Line-side receivers (levels as seen after the receivers)
    input  wire logic        line_rxd,
    input  wire logic        line_rxc,
    input  wire logic        line_cts,
    input  wire logic        line_dsr,
    input  wire logic        line_ri,
    input  wire logic        line_dcd,
    input  wire logic        line_tt_in,
    // Line-side drivers
    output logic             drv_txd,
    output logic             drv_rts,
    output logic             drv_dtr,
    output logic             drv_rl,
    output logic             drv_ll,
    output logic             drv_tt,
    output logic             drv_tt_oe_n,
    output logic             drv_st,
    output logic             drv_st_oe_n,
    output logic             drv_oe_n,
    output logic      [3:0]  drv_protocol,
    output logic      [3:0]  rcv_protocol,
    output logic             rcv_enable,
    output logic             adapter_interrogate
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0] out_proto_q;   // Bit 4 is continuous flag, low four code
    logic [3:0] in_proto_q;
    logic [3:0] if_cfg_q;
    logic [3:0] mask_q;
    logic [3:0] cause_q;
    logic [3:0] holder_q;
    logic [3:0] present_q;     // Line status seen one edge earlier
    logic [3:0] line_src_q;
    logic [3:0] ctrl_q;        // DTR, RTS, RL, LL control bits
    logic [3:0] adapt_q;
    logic       proto_written_q;
    logic       wr_pend_q;
    logic [3:0] wr_idx_q;
    logic       holder_init_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic       acc;
    logic       rd_acc;
    logic [3:0] acc_idx;
    logic       mapped;
    logic       cause_rd;

    assign acc      = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
    assign acc_idx  = haddr[5:2];
    assign mapped   = (haddr[31:6] == 26'd0) && (acc_idx <= IDX_ADAPT_CTRL);
    assign rd_acc   = acc && !hwrite;
    assign cause_rd = rd_acc && mapped && (acc_idx == IDX_CAUSE_MASK);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 4'h0;
        end
        else
        begin
            wr_pend_q <= acc && hwrite && mapped;
            wr_idx_q  <= acc_idx;
        end
    end

    // ------------------------------------------------------------
    // Line routing
    // ------------------------------------------------------------
    logic local_lb;
    logic remote_lb;
    logic txc_out_mode;
    logic dtr_src;
    logic rts_src;
    logic rl_src;
    logic ll_src;
    logic [3:0] present;       // RI, DCD, DSR, CTS as received, or from the transmit side in local loop, 1 = false
    logic drv_enable;

    assign local_lb     = if_cfg_q[CFG_LOCAL_BIT];
    assign remote_lb    = if_cfg_q[CFG_REMOTE_BIT];
    assign txc_out_mode = if_cfg_q[CFG_TXC_OUT];
    assign dtr_src      = line_src_q[SRC_DTR_BIT] ? ctrl_q[0] : dtr_in;
    assign rts_src      = line_src_q[SRC_RTS_BIT] ? ctrl_q[1] : rts_in;
    assign rl_src       = line_src_q[SRC_RL_BIT]  ? ctrl_q[2] : rl_in;
    assign ll_src       = line_src_q[SRC_LL_BIT]  ? ctrl_q[3] : ll_in;

    // Local loop replaces line inputs with transmit side, pairs fixed
    assign present = local_lb ? {~ll_src, ~rl_src, ~dtr_src, ~rts_src}
                              : {~line_ri, ~line_dcd, ~line_dsr, ~line_cts};

    // Drivers need protocol written, enable bit, valid code and mode gate
    assign drv_enable = proto_written_q && if_cfg_q[CFG_OUT_EN]
                     && (out_proto_q[3:0] != PROTO_OFF)
                     && PROTO_VALID[out_proto_q[3:0]]
                     && (out_proto_q[4] || dtr_src);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rxd_out      <= 1'b0;
            rxc_out      <= 1'b0;
            cts_out      <= 1'b0;
            dsr_out      <= 1'b0;
            ri_out       <= 1'b0;
            dcd_out      <= 1'b0;
            txc_out      <= 1'b0;
            drv_txd      <= 1'b0;
            drv_rts      <= 1'b0;
            drv_dtr      <= 1'b0;
            drv_rl       <= 1'b0;
            drv_ll       <= 1'b0;
            drv_tt       <= 1'b0;
            drv_st       <= 1'b0;
            drv_tt_oe_n  <= 1'b1;
            drv_st_oe_n  <= 1'b1;
            drv_oe_n     <= 1'b1;
            drv_protocol <= 4'h0;
            rcv_protocol <= 4'h0;
            rcv_enable   <= 1'b0;
        end
        else
        begin
            // Receive side: local loop is the logic-side loop
            rxd_out <= local_lb ? txd_in : line_rxd;
            rxc_out <= local_lb ? txc_in : line_rxc;
            txc_out <= txc_out_mode ? txc_in : line_tt_in;
            cts_out <= ~present[0];
            dsr_out <= ~present[1];
            dcd_out <= ~present[2];
            ri_out  <= ~present[3];
            // Drivers: remote loop returns line inputs to the line
            drv_txd <= remote_lb ? line_rxd : txd_in;
            drv_rts <= remote_lb ? line_cts : rts_src;
            drv_dtr <= remote_lb ? line_dsr : dtr_src;
            drv_rl  <= remote_lb ? line_dcd : rl_src;
            drv_ll  <= remote_lb ? line_ri  : ll_src;
            drv_tt  <= remote_lb ? line_rxc : txc_in;
            drv_st  <= remote_lb ? line_rxc : txc_in;
            drv_oe_n <= !drv_enable;
            // Clock direction and pin pair
            drv_tt_oe_n <= !(drv_enable && txc_out_mode && !adapt_q[ADC_ST_PIN_BIT]);
            drv_st_oe_n <= !(drv_enable && txc_out_mode && adapt_q[ADC_ST_PIN_BIT]);
            drv_protocol <= drv_enable ? out_proto_q[3:0] : PROTO_OFF;
            rcv_protocol <= in_proto_q;
            rcv_enable   <= (in_proto_q != PROTO_OFF) && PROTO_VALID[in_proto_q] && !local_lb;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            out_proto_q     <= 5'h00;
            in_proto_q      <= 4'h0;
            if_cfg_q        <= 4'h0;
            mask_q          <= 4'h0;
            line_src_q      <= 4'h0;
            ctrl_q          <= 4'h0;
            adapt_q         <= 4'h0;
            proto_written_q <= 1'b0;
        end
        else
        begin
            if (wr_pend_q)
            begin
                case (wr_idx_q)
                    IDX_OUT_PROTO:
                    begin
                        out_proto_q     <= {hwdata[OUT_CONT_BIT], hwdata[3:0]};
                        proto_written_q <= 1'b1;
                    end
                    IDX_IN_PROTO:   in_proto_q <= hwdata[3:0];
                    IDX_IF_CFG:     if_cfg_q   <= hwdata[3:0];
                    IDX_CAUSE_MASK: mask_q     <= hwdata[3:0];
                    IDX_LINE_SRC:   line_src_q <= hwdata[3:0];
                    IDX_DTR_CTRL:   ctrl_q[0]  <= hwdata[0];
                    IDX_RTS_CTRL:   ctrl_q[1]  <= hwdata[0];
                    IDX_RL_CTRL:    ctrl_q[2]  <= hwdata[0];
                    IDX_LL_CTRL:    ctrl_q[3]  <= hwdata[0];
                    IDX_ADAPT_CTRL:
                    begin
                        adapt_q <= hwdata[3:0];
                        if (hwdata[ADC_INTERR_BIT])
                        begin
                            if_cfg_q[CFG_OUT_EN] <= 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Status change detection
    // ------------------------------------------------------------
    logic [3:0] change;
    assign change = (present ^ holder_q) & mask_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            holder_q      <= 4'h0;
            holder_init_q <= 1'b0;
            cause_q       <= 4'h0;
            present_q     <= 4'h0;
        end
        else
        begin
            holder_init_q <= 1'b1;
            present_q     <= present;
            if (!holder_init_q || cause_rd)
            begin
                holder_q <= present;
            end
            if (cause_rd)
            begin
                // Read clears, but a step seen at the read edge survives
                cause_q <= (present ^ present_q) & mask_q;
            end
            else
            begin
                cause_q <= cause_q | change;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |cause_q;
        end
    end

    // ------------------------------------------------------------
    // Read data and response
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = REG_RESET;
        case (acc_idx)
            IDX_OUT_PROTO:  rd_byte = {out_proto_q[4], 3'b000, out_proto_q[3:0]};
            IDX_IN_PROTO:   rd_byte = {UNDEF_HIGH_BITS, in_proto_q};
            IDX_IF_CFG:     rd_byte = {4'h0, if_cfg_q};
            IDX_RX_STATUS:  rd_byte = {4'h0, present};
            IDX_CAUSE_MASK: rd_byte = {present, cause_q};
            IDX_LINE_SRC:   rd_byte = {4'h0, line_src_q};
            IDX_DTR_CTRL:   rd_byte = {7'h00, ctrl_q[0]};
            IDX_RTS_CTRL:   rd_byte = {7'h00, ctrl_q[1]};
            IDX_RL_CTRL:    rd_byte = {7'h00, ctrl_q[2]};
            IDX_LL_CTRL:    rd_byte = {7'h00, ctrl_q[3]};
            IDX_ADAPT_CTRL: rd_byte = {4'h0, adapt_q};
            default:        rd_byte = REG_RESET;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            adapter_interrogate <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            adapter_interrogate <= adapt_q[ADC_INTERR_BIT];
            if (rd_acc)
            begin
                hrdata <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_irq_follows_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        (|cause_q) |=> irq) else $error("irq not raised for set cause");

    a_cause_sticky_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (holder_init_q && !cause_rd) |=> ((cause_q & $past(cause_q)) == $past(cause_q)))
        else $error("cause bit dropped without read");

    a_read_clears_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        (holder_init_q && cause_rd) |=> (holder_q == $past(present)
            && cause_q == (($past(present) ^ $past(present_q)) & $past(mask_q))))
        else $error("cause read did not clear and relatch");

    a_mask_gates_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        ((cause_q & ~mask_q) == 4'h0) |=> ((cause_q & ~$past(mask_q)) == 4'h0))
        else $error("masked line set a cause");

    a_no_drive_unwritten: assert property (@(posedge hclk) disable iff (!hresetn)
        !proto_written_q |=> drv_oe_n) else $error("drivers on before protocol write");

    a_off_code_tristate: assert property (@(posedge hclk) disable iff (!hresetn)
        (out_proto_q[3:0] == PROTO_OFF) |=> (drv_oe_n && drv_protocol == PROTO_OFF))
        else $error("off code left drivers on");

    a_interrog_clears_en: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_q && wr_idx_q == IDX_ADAPT_CTRL && hwdata[ADC_INTERR_BIT])
        |=> !if_cfg_q[CFG_OUT_EN]) else $error("interrogation kept output enable");

    a_local_loop_map: assert property (@(posedge hclk) disable iff (!hresetn)
        local_lb |=> (rxd_out == $past(txd_in) && dsr_out == $past(dtr_src)))
        else $error("local loop pairing wrong");

    a_remote_loop_map: assert property (@(posedge hclk) disable iff (!hresetn)
        remote_lb |=> (drv_txd == $past(line_rxd) && drv_rts == $past(line_cts)))
        else $error("remote loop pairing wrong");

    a_dtr_source_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        (!remote_lb && line_src_q[SRC_DTR_BIT]) |=> (drv_dtr == $past(ctrl_q[0])))
        else $error("internal dtr not driven");

endmodule : mlc_line_config

`default_nettype wire

// >>> sim/mlc_remote_equipment.sv
// Remote serial equipment on the line side of the transceiver
`timescale 1ns/1ps
`default_nettype none

module mlc_remote_equipment
(
    input  wire logic       hclk,
    input  wire logic [6:0] want,
    output logic            line_rxd,
    output logic            line_rxc,
    output logic            line_cts,
    output logic            line_dsr,
    output logic            line_ri,
    output logic            line_dcd,
    output logic            line_tt_in
);
    // ------------------------------------------------------------
    // Line levels change just after an edge, 1 = true
    // ------------------------------------------------------------
    always_ff @(posedge hclk)
    begin
        {line_tt_in, line_rxd, line_rxc, line_cts, line_dsr, line_ri, line_dcd} <= want;
    end
endmodule : mlc_remote_equipment

`default_nettype wire

// >>> sim/test_mlc_line_config.sv
// Testbench: register access, routing, status change and driver enable checks
`timescale 1ns/1ps
`default_nettype none

module test_mlc_line_config
    import mlc_pkg::*;
;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = HSIZE_WORD;
    logic        txd_in = 0, txc_in = 0, rts_in = 0, dtr_in = 0, rl_in = 0, ll_in = 0;
    logic [6:0]  want = 7'h0f;
    logic        hreadyout, hresp, irq, rxd_out, rxc_out, cts_out, dsr_out, ri_out, dcd_out;
    logic        line_rxd, line_rxc, line_cts, line_dsr, line_ri, line_dcd, line_tt_in;
    logic        drv_txd, drv_rts, drv_dtr, drv_rl, drv_ll, drv_tt, drv_st, rcv_enable;
    logic        drv_tt_oe_n, drv_st_oe_n, drv_oe_n, adapter_interrogate, txc_out;
    logic [3:0]  drv_protocol, rcv_protocol;
    logic [5:0]  p;
    int          err_total = 0, samples_checked = 0;

    always #12.5 hclk = ~hclk;

    mlc_line_config dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txd_in(txd_in), .txc_in(txc_in),
        .rts_in(rts_in), .dtr_in(dtr_in), .rl_in(rl_in), .ll_in(ll_in), .rxd_out(rxd_out),
        .rxc_out(rxc_out), .cts_out(cts_out), .dsr_out(dsr_out), .ri_out(ri_out),
        .dcd_out(dcd_out), .irq(irq), .line_rxd(line_rxd), .line_rxc(line_rxc),
        .line_cts(line_cts), .line_dsr(line_dsr), .line_ri(line_ri), .line_dcd(line_dcd),
        .line_tt_in(line_tt_in), .drv_txd(drv_txd), .drv_rts(drv_rts), .drv_dtr(drv_dtr),
        .drv_rl(drv_rl), .drv_ll(drv_ll), .drv_tt(drv_tt), .drv_tt_oe_n(drv_tt_oe_n),
        .drv_st(drv_st), .drv_st_oe_n(drv_st_oe_n), .drv_oe_n(drv_oe_n),
        .drv_protocol(drv_protocol), .rcv_protocol(rcv_protocol), .rcv_enable(rcv_enable),
        .adapter_interrogate(adapter_interrogate), .txc_out(txc_out));

    mlc_remote_equipment remote (.hclk(hclk), .want(want), .line_rxd(line_rxd),
        .line_rxc(line_rxc), .line_cts(line_cts), .line_dsr(line_dsr), .line_ri(line_ri),
        .line_dcd(line_dcd), .line_tt_in(line_tt_in));

    // ------------------------------------------------------------
    // Closing report, comparisons and bus cycles
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("errors %0d, comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    task automatic chk_reg(input logic [31:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== {24'h00_0000, exp})
        begin
            err_total++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t pin %b expected %b", $time, got, exp);
        end
    endtask : chk_pin

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    // Waits one bus edge with hready high, bounded
    task automatic ready_edge;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            err_total++;
            $display("BAD %0t bus never ready", $time);
            complete_run();
        end
    endtask : ready_edge

    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] wd);
        hsel   <= 1'b1;
        haddr  <= {26'h000_0000, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        ready_edge();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        ready_edge();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk_reg(rd, exp);
    endtask : rd_chk

    initial
    begin
        tick(20000);
        err_total++;
        $display("BAD %0t run too long", $time);
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        tick(8);
        hresetn <= 1'b1;
        tick(1);
        rd_chk(IDX_IF_CFG, 8'h00);
        rd_chk(IDX_LINE_SRC, 8'h00);
        chk_pin(drv_oe_n, 1'b1);
        wr(IDX_IF_CFG, 8'h08);
        tick(3);
        chk_pin(drv_oe_n, 1'b1);
        for (int c = 0; c < 16; c++)
        begin
            wr(IDX_OUT_PROTO, {4'h8, c[3:0]});
            wr(IDX_IN_PROTO, {4'hf, c[3:0]});
            tick(3);
            chk_pin(drv_oe_n, !(c != 0 && PROTO_VALID[c]));
            chk_reg({28'h000_0000, drv_protocol},
                    (c != 0 && PROTO_VALID[c]) ? {4'h0, c[3:0]} : 8'h00);
            chk_reg({28'h000_0000, rcv_protocol}, {4'h0, c[3:0]});
            rd_chk(IDX_IN_PROTO, {UNDEF_HIGH_BITS, c[3:0]});
            if (c == 0)
                chk_pin(rcv_enable, 1'b0);
        end
        wr(IDX_OUT_PROTO, 8'h02);
        tick(3);
        chk_pin(drv_oe_n, 1'b1);
        dtr_in <= 1'b1;
        tick(3);
        chk_pin(drv_oe_n, 1'b0);
        wr(IDX_OUT_PROTO, 8'h82);
        rd_chk(IDX_OUT_PROTO, 8'h82);
        for (int m = 0; m < 4; m++)
        begin
            wr(IDX_IF_CFG, 8'h08 | m[7:0]);
            for (int k = 0; k < 2; k++)
            begin
                p = k ? 6'h15 : 6'h2a;
                want <= {1'b0, p};
                {txd_in, txc_in, rts_in, dtr_in, ll_in, rl_in} <= ~p;
                tick(4);
                chk_reg({26'h0, rxd_out, rxc_out, cts_out, dsr_out, ri_out, dcd_out},
                        {2'b00, m[0] ? ~p : p});
                chk_reg({25'h000_0000, drv_st, drv_txd, drv_tt, drv_rts, drv_dtr, drv_ll, drv_rl},
                        m[1] ? {1'b0, p[4], p} : {1'b0, ~p[4], ~p});
            end
        end
        wr(IDX_IF_CFG, 8'h08);
        want <= 7'h0f;
        tick(4);
        rd_chk(IDX_CAUSE_MASK, 8'h00);
        wr(IDX_CAUSE_MASK, 8'h02);
        want <= 7'h0b;
        tick(4);
        chk_pin(irq, 1'b1);
        rd_chk(IDX_RX_STATUS, 8'h02);
        want <= 7'h0f;
        tick(4);
        chk_pin(irq, 1'b1);
        rd_chk(IDX_CAUSE_MASK, 8'h02);
        tick(3);
        chk_pin(irq, 1'b0);
        rd_chk(IDX_CAUSE_MASK, 8'h00);
        want <= 7'h07;
        tick(4);
        chk_pin(irq, 1'b0);
        rd_chk(IDX_CAUSE_MASK, 8'h10);
        want <= 7'h03;
        tick(1);
        rd_chk(IDX_CAUSE_MASK, 8'h30);
        tick(3);
        chk_pin(irq, 1'b1);
        rd_chk(IDX_CAUSE_MASK, 8'h32);
        wr(IDX_DTR_CTRL, 8'h01);
        wr(IDX_RTS_CTRL, 8'h00);
        {dtr_in, rts_in} <= 2'b01;
        want <= 7'h43;
        for (int s = 3; s >= 0; s -= 3)
        begin
            wr(IDX_LINE_SRC, s[7:0]);
            tick(3);
            chk_pin(drv_dtr, s[0]);
            chk_pin(drv_rts, !s[1]);
        end
        chk_pin(drv_tt_oe_n, 1'b1);
        chk_pin(txc_out, 1'b1);
        wr(IDX_IF_CFG, 8'h0c);
        tick(3);
        chk_pin(drv_tt_oe_n, 1'b0);
        chk_pin(txc_out, 1'b0);
        chk_pin(drv_st_oe_n, 1'b1);
        wr(IDX_ADAPT_CTRL, 8'h01);
        tick(3);
        chk_pin(drv_tt_oe_n, 1'b1);
        chk_pin(drv_st_oe_n, 1'b0);
        wr(IDX_ADAPT_CTRL, 8'h08);
        tick(3);
        rd_chk(IDX_IF_CFG, 8'h04);
        chk_pin(drv_oe_n, 1'b1);
        chk_pin(adapter_interrogate, 1'b1);
        wr(IDX_ADAPT_CTRL, 8'h00);
        wr(IDX_IF_CFG, 8'h08);
        tick(3);
        chk_pin(drv_oe_n, 1'b0);
        chk_pin(adapter_interrogate, 1'b0);
        rd_chk(4'hf, 8'h00);
        chk_pin(hresp, 1'b0);
        complete_run();
    end
endmodule : test_mlc_line_config

`default_nettype wire
